// >>> dsss_pkg.sv
`default_nettype none
package dsss_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_LOW_NS = 25;
	localparam int RESET_CYCLES = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// Device register indexes
	// ----------------------------------------
	localparam logic [5:0] REG_MAIN_CONTROL = 6'h00;
	localparam logic [5:0] REG_INTERFACE_CHECK_CONTROL = 6'h01;
	localparam logic [5:0] REG_DATAPATH_SHUTOFF_CONTROL = 6'h02;
	localparam logic [5:0] REG_OUTPUT_CURRENT_CONTROL = 6'h03;
	localparam logic [5:0] REG_ALARM_STATUS = 6'h05;
	localparam logic [5:0] REG_ALARM_MASK = 6'h07;
	localparam logic [5:0] REG_CHAN_I_OFFSET = 6'h08;
	localparam logic [5:0] REG_FIFO_AND_CHAN_Q_OFFSET = 6'h09;
	localparam logic [5:0] REG_CHAN_I_GAIN = 6'h0c;
	localparam logic [5:0] REG_CHAN_Q_GAIN = 6'h0d;
	localparam logic [5:0] REG_IQ_PHASE_CORRECTION = 6'h10;
	localparam logic [5:0] REG_OSCILLATOR_PHASE_OFFSET = 6'h12;
	localparam logic [5:0] REG_OSCILLATOR_FREQ_WORD_A = 6'h14;
	localparam logic [5:0] REG_OSCILLATOR_FREQ_WORD_B = 6'h15;
	localparam logic [5:0] REG_PLL_CONTROL = 6'h18;
	localparam logic [5:0] REG_PLL_DIVIDER_CONTROL = 6'h19;
	localparam logic [5:0] REG_PLL_VCO_TUNE = 6'h1a;
	localparam logic [5:0] REG_REFERENCE_FUSE_CONTROL = 6'h1b;
	localparam logic [5:0] REG_CORRECTION_SYNC_SELECT = 6'h1e;
	localparam logic [5:0] REG_MIXER_OSCILLATOR_SYNC_SELECT = 6'h1f;
	localparam logic [5:0] REG_FIFO_DIVIDER_SYNC_SELECT = 6'h20;
	localparam int REG_COUNT = 33;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_MAIN_CONTROL = 16'h049c;
	localparam logic [15:0] RST_INTERFACE_CHECK_CONTROL = 16'h050e;
	localparam logic [15:0] RST_DATAPATH_SHUTOFF_CONTROL = 16'h7000;
	localparam logic [15:0] RST_OUTPUT_CURRENT_CONTROL = 16'hf000;
	localparam logic [15:0] RST_ALARM_MASK = 16'hffff;
	localparam logic [15:0] RST_OTHER = 16'h0000;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_DIV_ALIGN_EN = 2;
	localparam int BIT_PLL_ENABLE = 2;
	localparam int BIT_PREDIV_ALIGN_EN = 11;
	localparam int BIT_FUSE_SLEEP = 11;
	localparam int BIT_SIF_TXENABLE = 0;
	localparam int BIT_SIF_SYNC = 1;
	localparam int BIT_DIV_SYNC_SEL = 0;
	localparam int LSB_WR_SYNC_SEL = 12;
	localparam int LSB_RD_SYNC_SEL = 8;
	localparam int LSB_FMT_SYNC_SEL = 2;
	localparam int BIT_SHUT_DACCLK = 14;
	localparam int BIT_SHUT_DATACLK = 13;
	localparam int BIT_SHUT_COLLISION = 12;
	localparam int BIT_ALM_COLLISION = 13;
	localparam int BIT_ALM_DACCLK = 10;
	localparam int BIT_ALM_DATACLK = 9;
	localparam int BIT_IFCHK_BIT8 = 8;
	// Sync source bit positions in the one-hot pointer fields
	localparam int SRC_SOFT = 0;
	localparam int SRC_FRAME = 1;
	localparam int SRC_SYNC = 2;
	localparam int SRC_STROBE = 3;
	localparam logic [2:0] RD_PTR_OFFSET = 3'h4;
	// ----------------------------------------
	// Host AXI map (byte addresses) and host init write values
	// ----------------------------------------
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_STATUS = 8'h04;
	localparam logic [7:0] HOST_DEV_CMD = 8'h08;
	localparam logic [7:0] HOST_DEV_RDATA = 8'h0c;
	localparam logic [7:0] HOST_PULSE = 8'h10;
	localparam logic [15:0] INIT_IFCHK = 16'h040e;
	localparam logic [15:0] INIT_IQ_PHASE = 16'h3000;
	localparam logic [15:0] INIT_FUSE = 16'h0800;
endpackage
`default_nettype wire

// >>> dsss_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dsss_link_if;
	logic rst_pin_n;
	logic txenable;
	logic frame;
	logic sync;
	logic output_strobe;
	logic alarm;
	logic reg_wr;
	logic reg_rd;
	logic [5:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	modport dev (input rst_pin_n, txenable, frame, sync, output_strobe, reg_wr, reg_rd,
		reg_addr, reg_wdata, output alarm, reg_rdata, reg_rvalid);
	modport host (output rst_pin_n, txenable, frame, sync, output_strobe, reg_wr, reg_rd,
		reg_addr, reg_wdata, input alarm, reg_rdata, reg_rvalid);
endinterface
`default_nettype wire

// >>> dsss_device.sv
// Functional notes
// - Single mode: read reset resampled from write
// - PLL single mode: strobe never aligns read
// - Host holds tx low, reset 25 ns
// - Host writes bit8=0, phase 13:12=11b
// - Fuse power-down bit sleeps fuses
// - Pointer sources from bits 15:12, 11:8
// - Formatter source from bits 3:2
// - Divider source bit0, gated by enable
// - Pre-divider align enable bit 11
// - Source applies all link inputs together
// - Single mode: one rising sync edge
// - Dual mode: pulse or periodic aligns
// - Alignment pulse meets reference setup/hold
// - Host may clear divider align enable
// - Strobe-sourced divider align may stay on
// - Zeroed pointer sources disable; pulses harmless
// - Transmit on pin or register bit
// - Host resyncs on clock loss/collision; code only drops tx on alarm
// - Shut off outputs on enabled faults
// - Alarm mask gates alarm output
// - Offset/phase writes trigger auto alignment
// - Writing zero clears latched alarms
`timescale 1ns/100ps
`default_nettype none
module dsss_device #(
	parameter int DIV_RATIO = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	dsss_link_if.dev link,
	input wire logic dataclk_lost_in,
	input wire logic dacclk_lost_in,
	output logic tx_active_out,
	output logic mute_out,
	output logic fuse_sleep_out,
	output logic [2:0] wr_ptr_out,
	output logic [2:0] rd_ptr_out,
	output logic [1:0] fmt_phase_out,
	output logic [1:0] div_phase_out,
	output logic prediv_align_out,
	output logic [2:0] autosync_out
);
	if (DIV_RATIO < 2 || DIV_RATIO > 4) begin : g_bad_ratio
		$error("DIV_RATIO must be 2..4");
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] reset_value(input int idx);
		unique case (idx)
			int'(dsss_pkg::REG_MAIN_CONTROL): reset_value = dsss_pkg::RST_MAIN_CONTROL;
			int'(dsss_pkg::REG_INTERFACE_CHECK_CONTROL): reset_value = dsss_pkg::RST_INTERFACE_CHECK_CONTROL;
			int'(dsss_pkg::REG_DATAPATH_SHUTOFF_CONTROL): reset_value = dsss_pkg::RST_DATAPATH_SHUTOFF_CONTROL;
			int'(dsss_pkg::REG_OUTPUT_CURRENT_CONTROL): reset_value = dsss_pkg::RST_OUTPUT_CURRENT_CONTROL;
			int'(dsss_pkg::REG_ALARM_MASK): reset_value = dsss_pkg::RST_ALARM_MASK;
			default: reset_value = dsss_pkg::RST_OTHER;
		endcase
	endfunction
	function automatic logic src_hit(input logic [3:0] sel, input logic [3:0] ev);
		src_hit = |(sel & ev);
	endfunction
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] pin_meta_ff;
	logic [4:0] pin_sync_ff;
	logic [4:0] pin_prev_ff;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pin_meta_ff <= 5'h01;
			pin_sync_ff <= 5'h01;
			pin_prev_ff <= 5'h01;
		end else begin
			pin_meta_ff <= {link.output_strobe, link.sync, link.frame, link.txenable, link.rst_pin_n};
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end
	logic soft_rst;
	logic frame_rise;
	logic sync_rise;
	logic strobe_rise;
	assign soft_rst = !pin_sync_ff[0];
	assign frame_rise = pin_sync_ff[2] && !pin_prev_ff[2];
	assign sync_rise = pin_sync_ff[3] && !pin_prev_ff[3];
	assign strobe_rise = pin_sync_ff[4] && !pin_prev_ff[4];
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [15:0] regs_ff [0:dsss_pkg::REG_COUNT-1];
	logic [15:0] alarm_ff;
	logic wr_hit;
	int widx;
	assign widx = int'(link.reg_addr);
	assign wr_hit = link.reg_wr && (widx < dsss_pkg::REG_COUNT);
	genvar gi;
	generate
		for (gi = 0; gi < dsss_pkg::REG_COUNT; gi++) begin : g_reg
			always_ff @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					regs_ff[gi] <= reset_value(gi);
				end else if (soft_rst) begin
					regs_ff[gi] <= reset_value(gi);
				end else if (wr_hit && widx == gi && gi != int'(dsss_pkg::REG_ALARM_STATUS)) begin
					regs_ff[gi] <= link.reg_wdata;
				end
			end
		end
	endgenerate
	logic [15:0] main_r;
	logic [15:0] shut_r;
	logic [15:0] pll_r;
	logic [15:0] mix_r;
	logic [15:0] fsel_r;
	assign main_r = regs_ff[dsss_pkg::REG_MAIN_CONTROL];
	assign shut_r = regs_ff[dsss_pkg::REG_DATAPATH_SHUTOFF_CONTROL];
	assign pll_r = regs_ff[dsss_pkg::REG_PLL_CONTROL];
	assign mix_r = regs_ff[dsss_pkg::REG_MIXER_OSCILLATOR_SYNC_SELECT];
	assign fsel_r = regs_ff[dsss_pkg::REG_FIFO_DIVIDER_SYNC_SELECT];
	// Read port: one cycle, indexes past the register file give zero
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.reg_rdata <= 16'h0000;
			link.reg_rvalid <= 1'b0;
		end else begin
			link.reg_rvalid <= link.reg_rd;
			if (link.reg_rd) begin
				if (link.reg_addr == dsss_pkg::REG_ALARM_STATUS) begin
					link.reg_rdata <= alarm_ff;
				end else if (int'(link.reg_addr) < dsss_pkg::REG_COUNT) begin
					link.reg_rdata <= regs_ff[int'(link.reg_addr)];
				end else begin
					link.reg_rdata <= 16'h0000;
				end
			end
		end
	end
	// ----------------------------------------
	// Sync events and source selection
	// ----------------------------------------
	logic soft_sync;
	logic [3:0] ev;
	logic [3:0] wr_sel;
	logic [3:0] rd_sel;
	logic dual_mode;
	logic wr_align;
	logic rd_align;
	logic fmt_align;
	logic div_align;
	assign soft_sync = wr_hit && link.reg_addr == dsss_pkg::REG_MIXER_OSCILLATOR_SYNC_SELECT
		&& link.reg_wdata[dsss_pkg::BIT_SIF_SYNC];
	assign ev = {strobe_rise, sync_rise, frame_rise, soft_sync};
	assign wr_sel = fsel_r[dsss_pkg::LSB_WR_SYNC_SEL +: 4];
	assign rd_sel = fsel_r[dsss_pkg::LSB_RD_SYNC_SEL +: 4];
	// Dual mode only when the read source is the strobe and PLL is off
	assign dual_mode = rd_sel[dsss_pkg::SRC_STROBE] && !pll_r[dsss_pkg::BIT_PLL_ENABLE];
	assign wr_align = src_hit(wr_sel, ev);
	// Resampled write reset: latency may shift a cycle across devices
	logic [1:0] rd_hand_ff;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_hand_ff <= 2'h0;
		end else begin
			rd_hand_ff <= {rd_hand_ff[0], wr_align && rd_sel != 4'h0};
		end
	end
	assign rd_align = dual_mode ? src_hit(rd_sel, ev) : rd_hand_ff[1];
	assign fmt_align = !mix_r[dsss_pkg::LSB_FMT_SYNC_SEL + 1]
		&& (mix_r[dsss_pkg::LSB_FMT_SYNC_SEL] ? sync_rise : frame_rise);
	assign div_align = main_r[dsss_pkg::BIT_DIV_ALIGN_EN]
		&& (fsel_r[dsss_pkg::BIT_DIV_SYNC_SEL] ? strobe_rise : frame_rise);
	// ----------------------------------------
	// Pointers, formatter, dividers
	// ----------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_out <= 3'h0;
			rd_ptr_out <= dsss_pkg::RD_PTR_OFFSET;
		end else begin
			wr_ptr_out <= wr_align ? 3'h0 : wr_ptr_out + 3'h1;
			rd_ptr_out <= rd_align ? dsss_pkg::RD_PTR_OFFSET : rd_ptr_out + 3'h1;
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fmt_phase_out <= 2'h0;
			div_phase_out <= 2'h0;
		end else begin
			fmt_phase_out <= fmt_align ? 2'h0 : fmt_phase_out + 2'h1;
			if (div_align || int'(div_phase_out) == DIV_RATIO - 1) begin
				div_phase_out <= 2'h0;
			end else begin
				div_phase_out <= div_phase_out + 2'h1;
			end
		end
	end
	// Pre-divider realigns on sync edge while enabled
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prediv_align_out <= 1'b0;
		end else begin
			prediv_align_out <= pll_r[dsss_pkg::BIT_PREDIV_ALIGN_EN] && sync_rise;
		end
	end
	// Auto alignment strobes: I offset, IQ phase, oscillator phase
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			autosync_out <= 3'h0;
		end else begin
			autosync_out[0] <= wr_hit && link.reg_addr == dsss_pkg::REG_CHAN_I_OFFSET;
			autosync_out[1] <= wr_hit && link.reg_addr == dsss_pkg::REG_IQ_PHASE_CORRECTION;
			autosync_out[2] <= wr_hit
				&& link.reg_addr == dsss_pkg::REG_OSCILLATOR_PHASE_OFFSET;
		end
	end
	// ----------------------------------------
	// Alarms and output gating
	// ----------------------------------------
	logic collision;
	logic [15:0] alarm_set;
	assign collision = wr_ptr_out == rd_ptr_out;
	always_comb begin
		alarm_set = 16'h0000;
		alarm_set[dsss_pkg::BIT_ALM_COLLISION] = collision;
		alarm_set[dsss_pkg::BIT_ALM_DACCLK] = dacclk_lost_in;
		alarm_set[dsss_pkg::BIT_ALM_DATACLK] = dataclk_lost_in;
	end
	// New events win over a clearing write
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			alarm_ff <= 16'h0000;
		end else if (soft_rst) begin
			alarm_ff <= 16'h0000;
		end else if (wr_hit && link.reg_addr == dsss_pkg::REG_ALARM_STATUS
			&& link.reg_wdata == 16'h0000) begin
			alarm_ff <= alarm_set;
		end else begin
			alarm_ff <= alarm_ff | alarm_set;
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.alarm <= 1'b0;
			mute_out <= 1'b0;
			tx_active_out <= 1'b0;
			fuse_sleep_out <= 1'b0;
		end else begin
			link.alarm <= |(alarm_ff & ~regs_ff[dsss_pkg::REG_ALARM_MASK]);
			mute_out <= (shut_r[dsss_pkg::BIT_SHUT_COLLISION] && collision)
				|| (shut_r[dsss_pkg::BIT_SHUT_DACCLK] && dacclk_lost_in)
				|| (shut_r[dsss_pkg::BIT_SHUT_DATACLK] && dataclk_lost_in);
			tx_active_out <= pin_sync_ff[1]
				|| regs_ff[dsss_pkg::REG_OUTPUT_CURRENT_CONTROL][dsss_pkg::BIT_SIF_TXENABLE];
			fuse_sleep_out <=
				regs_ff[dsss_pkg::REG_REFERENCE_FUSE_CONTROL][dsss_pkg::BIT_FUSE_SLEEP];
		end
	end
endmodule // dsss_device
`default_nettype wire

// >>> dsss_host.sv
`timescale 1ns/100ps
`default_nettype none
module dsss_host (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	dsss_link_if.host link,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RESET = 2'b01,
		ST_INIT = 2'b10
	} dsss_seq_t;
	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	logic aw_ff;
	logic w_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic do_wr;
	assign s_axi_awready = !aw_ff;
	assign s_axi_wready = !w_ff;
	assign do_wr = aw_ff && w_ff && !s_axi_bvalid;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_ff) begin
				aw_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_ff) begin
				w_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
			end
		end
	end
	assign s_axi_bresp = 2'b00;
	assign s_axi_rresp = 2'b00;
	// ----------------------------------------
	// Control state
	// ----------------------------------------
	dsss_seq_t state_ff;
	logic [1:0] cnt_ff;
	logic txen_ff;
	logic done_ff;
	logic dropped_ff;
	logic [15:0] rdata_ff;
	logic [2:0] pulse_ff;
	logic [1:0] alarm_sync_ff;
	logic start;
	logic cmd;
	assign start = do_wr && awaddr_ff == dsss_pkg::HOST_CTRL && wdata_ff[0];
	assign cmd = do_wr && awaddr_ff == dsss_pkg::HOST_DEV_CMD && state_ff == ST_IDLE;
	// Alarm pin is two-flopped like any pin
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			alarm_sync_ff <= 2'h0;
		end else begin
			alarm_sync_ff <= {alarm_sync_ff[0], link.alarm};
		end
	end
	// Alarm beats software so a faulted link never keeps transmitting
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			txen_ff <= 1'b0;
			dropped_ff <= 1'b0;
		end else if (alarm_sync_ff[1] && txen_ff) begin
			txen_ff <= 1'b0;
			dropped_ff <= 1'b1;
		end else if (start) begin
			txen_ff <= 1'b0;
		end else if (do_wr && awaddr_ff == dsss_pkg::HOST_CTRL) begin
			txen_ff <= wdata_ff[1] && state_ff == ST_IDLE;
			dropped_ff <= dropped_ff && !wdata_ff[2];
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 2'h0;
			done_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (start) begin
						state_ff <= ST_RESET;
						cnt_ff <= 2'h0;
						done_ff <= 1'b0;
					end
				end
				ST_RESET: begin
					if (int'(cnt_ff) == dsss_pkg::RESET_CYCLES - 1) begin
						state_ff <= ST_INIT;
						cnt_ff <= 2'h0;
					end else begin
						cnt_ff <= cnt_ff + 2'h1;
					end
				end
				ST_INIT: begin
					if (cnt_ff == 2'h3) begin
						state_ff <= ST_IDLE;
						done_ff <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff + 2'h1;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------
	// Device port drive
	// ----------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			link.reg_addr <= 6'h00;
			link.reg_wdata <= 16'h0000;
		end else begin
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			// Slot 0 idles: the device still sees its reset pin low behind two flops
			if (state_ff == ST_INIT && cnt_ff != 2'h0) begin
				link.reg_wr <= 1'b1;
				unique case (cnt_ff)
					2'h1: begin
						link.reg_addr <= dsss_pkg::REG_INTERFACE_CHECK_CONTROL;
						link.reg_wdata <= dsss_pkg::INIT_IFCHK;
					end
					2'h2: begin
						link.reg_addr <= dsss_pkg::REG_IQ_PHASE_CORRECTION;
						link.reg_wdata <= dsss_pkg::INIT_IQ_PHASE;
					end
					default: begin
						link.reg_addr <= dsss_pkg::REG_REFERENCE_FUSE_CONTROL;
						link.reg_wdata <= dsss_pkg::INIT_FUSE;
					end
				endcase
			end else if (cmd) begin
				link.reg_wr <= !wdata_ff[31];
				link.reg_rd <= wdata_ff[31];
				link.reg_addr <= wdata_ff[21:16];
				link.reg_wdata <= wdata_ff[15:0];
			end
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_ff <= 16'h0000;
			pulse_ff <= 3'h0;
		end else begin
			if (link.reg_rvalid) begin
				rdata_ff <= link.reg_rdata;
			end
			pulse_ff <= (do_wr && awaddr_ff == dsss_pkg::HOST_PULSE) ? wdata_ff[2:0] : 3'h0;
		end
	end
	// Pins launch together: tx and pulses from flops, rst_pin_n decoded from state_ff
	assign link.rst_pin_n = state_ff != ST_RESET;
	assign link.txenable = txen_ff;
	assign link.frame = pulse_ff[0];
	assign link.sync = pulse_ff[1];
	assign link.output_strobe = pulse_ff[2];
	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				dsss_pkg::HOST_CTRL: s_axi_rdata <= {30'h0, txen_ff, 1'b0};
				dsss_pkg::HOST_STATUS: s_axi_rdata <= {28'h0, dropped_ff, alarm_sync_ff[1],
					done_ff, state_ff != ST_IDLE};
				dsss_pkg::HOST_DEV_RDATA: s_axi_rdata <= {16'h0, rdata_ff};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // dsss_host
`default_nettype wire

// >>> dsss_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dsss_checker (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic rst_pin_n,
	input wire logic txenable,
	input wire logic frame,
	input wire logic alarm,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rvalid
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// ----------------------------------------
	// Link rules
	// ----------------------------------------
	sequence s_pin_low;
		!rst_pin_n [*3];
	endsequence
	a_reset_low_width: assert property ($fell(rst_pin_n) |-> s_pin_low ##1 rst_pin_n)
		else $error("reset pin pulse width wrong");
	a_tx_held_low: assert property (!rst_pin_n |-> !txenable)
		else $error("transmit gate high in reset");
	a_no_reset_write: assert property (!rst_pin_n |-> !reg_wr)
		else $error("register write during reset");
	a_ifchk_bit_clear: assert property (reg_wr && reg_addr == 6'h01 |-> !reg_wdata[8])
		else $error("interface check bit 8 set");
	a_phase_bits_set: assert property (reg_wr && reg_addr == 6'h10 |-> reg_wdata[13:12] == 2'h3)
		else $error("phase bits 13:12 not 11b");
	a_fuse_sleep_set: assert property (reg_wr && reg_addr == 6'h1b |-> reg_wdata[11])
		else $error("fuse sleep bit clear");
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_rvalid_single: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read answer without request");
	// Two synchroniser flops plus the gate flop in the host
	a_alarm_drops_tx: assert property (alarm |-> ##[0:3] !txenable)
		else $error("transmit gate kept on alarm");
	a_frame_pulse: assert property (frame |=> !frame)
		else $error("frame pulse too long");
endmodule // dsss_checker
`default_nettype wire

// >>> dac_startup_sync_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dac_startup_sync_sequencer_tb;
	logic core_clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, dl = 1'h0, dc = 1'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat, d;
	logic awr, wr_rdy, bv, arr, rv, tx, mute, fuse, pdv;
	logic [1:0] bresp, rresp, fp, dp;
	logic [2:0] wp, rp, aus;
	logic [3:0] seen = 4'h0;
	int err_count = 0, checks = 0, n;
	dsss_link_if link ();
	always #5 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) seen <= seen | {pdv, aus};
	dsss_host dsss_host_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp));
	dsss_device dsss_device_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link(link),
		.dataclk_lost_in(dl), .dacclk_lost_in(dc), .tx_active_out(tx), .mute_out(mute),
		.fuse_sleep_out(fuse), .wr_ptr_out(wp), .rd_ptr_out(rp), .fmt_phase_out(fp),
		.div_phase_out(dp), .prediv_align_out(pdv), .autosync_out(aus));
	dsss_checker dsss_checker_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.rst_pin_n(link.rst_pin_n), .txenable(link.txenable), .frame(link.frame),
		.alarm(link.alarm), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_rvalid(link.reg_rvalid));
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo(input int k);
		if (k >= 40) begin
			err_count++;
			$display("BAD t=%0t timeout", $time);
			summarize();
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		@(posedge core_clk_in);
		awv <= 1'h1;
		wv <= 1'h1;
		awa <= a;
		wd <= v;
		bry <= 1'h1;
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk_in);
			if (awr) awv <= 1'h0;
			if (wr_rdy) wv <= 1'h0;
			if (bv === 1'h1) break;
		end
		bry <= 1'h0;
		tmo(k);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
		int k;
		@(posedge core_clk_in);
		arv <= 1'h1;
		ara <= a;
		rry <= 1'h1;
		for (k = 0; k < 40; k++) begin
			@(posedge core_clk_in);
			if (arr) arv <= 1'h0;
			if (rv === 1'h1) break;
		end
		v = rdat;
		rry <= 1'h0;
		tmo(k);
	endtask
	// Command goes out the cycle after the write; four cycles covers the read answer
	task automatic dev_wr(input logic [5:0] i, input logic [15:0] v);
		axi_wr(dsss_pkg::HOST_DEV_CMD, {10'h0, i, v});
		repeat (4) @(posedge core_clk_in);
	endtask
	task automatic dev_rd(input logic [5:0] i, input logic [15:0] e);
		axi_wr(dsss_pkg::HOST_DEV_CMD, {1'h1, 9'h0, i, 16'h0});
		repeat (4) @(posedge core_clk_in);
		axi_rd(dsss_pkg::HOST_DEV_RDATA, d);
		chk({16'h0, d[15:0]}, {16'h0, e});
	endtask
	task automatic pulse_ptr(input logic [31:0] p, input logic [2:0] e);
		axi_wr(dsss_pkg::HOST_PULSE, p);
		repeat (8) @(posedge core_clk_in);
		chk({29'h0, rp - wp}, {29'h0, e});
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge core_clk_in);
		rst_n_in <= 1'h1;
		axi_rd(dsss_pkg::HOST_DEV_RDATA, d);
		axi_wr(dsss_pkg::HOST_DEV_CMD, {1'h1, 9'h0, 6'h00, 16'h0});
		repeat (4) @(posedge core_clk_in);
		axi_rd(dsss_pkg::HOST_DEV_RDATA, d);
		chk({16'h0, d[15:0]}, {16'h0, dsss_pkg::RST_MAIN_CONTROL});
		$display("test defaults done");
		axi_wr(dsss_pkg::HOST_CTRL, 32'h1);
		for (n = 0; n < 40; n++) begin
			axi_rd(dsss_pkg::HOST_STATUS, d);
			if (d[1] === 1'h1) break;
		end
		tmo(n);
		dev_rd(6'h21, 16'h0000);
		dev_rd(6'h02, dsss_pkg::RST_DATAPATH_SHUTOFF_CONTROL);
		dev_rd(6'h01, dsss_pkg::INIT_IFCHK);
		chk({31'h0, fuse}, 32'h1);
		chk({28'h0, seen}, 32'h2);
		$display("test start done");
		dev_wr(6'h20, 16'h2200);
		pulse_ptr(32'h1, dsss_pkg::RD_PTR_OFFSET - 3'h2);
		chk({30'h0, fp}, 32'h1);
		chk({30'h0, dp}, 32'h1);
		dev_wr(6'h20, 16'h2800);
		pulse_ptr(32'h5, dsss_pkg::RD_PTR_OFFSET);
		pulse_ptr(32'h5, dsss_pkg::RD_PTR_OFFSET);
		dev_wr(6'h18, 16'h0004);
		pulse_ptr(32'h5, dsss_pkg::RD_PTR_OFFSET - 3'h2);
		dev_wr(6'h20, 16'h0000);
		pulse_ptr(32'h5, dsss_pkg::RD_PTR_OFFSET - 3'h2);
		$display("test pointers done");
		dev_wr(6'h03, 16'hf001);
		chk({31'h0, tx}, 32'h1);
		dev_wr(6'h03, 16'hf000);
		chk({31'h0, tx}, 32'h0);
		axi_wr(dsss_pkg::HOST_CTRL, 32'h2);
		repeat (6) @(posedge core_clk_in);
		chk({31'h0, tx}, 32'h1);
		dev_wr(6'h08, 16'h0001);
		dev_wr(6'h10, 16'h3000);
		dev_wr(6'h12, 16'h0001);
		dev_wr(6'h18, 16'h0800);
		axi_wr(dsss_pkg::HOST_PULSE, 32'h2);
		repeat (6) @(posedge core_clk_in);
		chk({28'h0, seen}, 32'hf);
		$display("test tx and align done");
		dev_wr(6'h07, 16'hd8ff);
		dl <= 1'h1;
		repeat (6) @(posedge core_clk_in);
		chk({31'h0, mute}, 32'h1);
		axi_rd(dsss_pkg::HOST_STATUS, d);
		chk({30'h0, d[3:2]}, 32'h3);
		chk({31'h0, link.txenable}, 32'h0);
		dl <= 1'h0;
		dev_wr(6'h05, 16'h0000);
		dev_rd(6'h05, 16'h0000);
		chk({31'h0, mute}, 32'h0);
		dc <= 1'h1;
		repeat (3) @(posedge core_clk_in);
		dc <= 1'h0;
		dev_rd(6'h05, 16'h0400);
		$display("test alarms done");
		summarize();
	end
endmodule // dac_startup_sync_sequencer_tb
`default_nettype wire
